// ==== include/csp_pkg.sv ====
// Package of constants and carrier types for the status and pointer-select block
package csp_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] CSP_OFS_STATUS = 12'h0d0;
	localparam logic [11:0] CSP_OFS_PSEL = 12'h092;
	localparam logic [11:0] CSP_OFS_CTRL = 12'h100;
	localparam logic [11:0] CSP_OFS_ACC = 12'h104;
	localparam logic [11:0] CSP_OFS_DPTR = 12'h108;
	localparam logic [11:0] CSP_OFS_MAP = 12'h10c;
	localparam logic [7:0] CSP_STATUS_RST = 8'h00;
	localparam logic [2:0] CSP_PSEL_RST = 3'h0;
	// Status bit positions
	localparam int CSP_BIT_CARRY = 7;
	localparam int CSP_BIT_NIBBLE = 6;
	localparam int CSP_BIT_OVF = 2;
	localparam int CSP_BIT_PARITY = 0;
	localparam int CSP_BIT_BANK_LO = 3;
	localparam int CSP_BIT_BANK_HI = 4;
	localparam int CSP_BIT_UF0 = 5;
	localparam int CSP_BIT_UF1 = 1;
	// Space sizes
	localparam int CSP_IDATA_BYTES = 256;
	localparam int CSP_SFR_BYTES = 128;
	localparam logic [7:0] CSP_SFR_BASE = 8'h80;
	localparam int CSP_BANK_BYTES = 8;
	// Reset timing
	localparam int CSP_RESET_OSC_PERIODS = 12;
	// Control register fields
	localparam int CSP_CTRL_STEP = 0;
	localparam int CSP_CTRL_ARITH = 1;
	localparam int CSP_CTRL_SUB = 2;
	localparam int CSP_CTRL_CIN = 3;
	localparam int CSP_CTRL_INC = 4;
	localparam int CSP_CTRL_OPB_LO = 8;
	localparam int CSP_CTRL_OPB_HI = 15;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} csp_apb_rsp_type;

	typedef struct packed {
		logic [15:0] ext_addr;
		logic [7:0] bank_base;
	} csp_map_type;
endpackage : csp_pkg

// ==== design/csp_core.sv ====
// Status word, bank decode and eight data pointers behind an apb slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module csp_core #(
	parameter int NUM_PTRS = 8,
	parameter int PTR_WIDTH = 16
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic core_reset,
	// Apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output csp_pkg::csp_apb_rsp_type apb_rsp,
	// Core view
	output csp_pkg::csp_map_type map_out,
	output logic [7:0] status_out,
	output logic core_in_reset
);
	import csp_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic carry_flag;
		logic nibble_carry_flag;
		logic user_flag_zero;
		logic bank_select_high;
		logic bank_select_low;
		logic signed_overflow_flag;
		logic user_flag_one;
		logic parity_flag;
		logic [7:0] acc;
		logic [2:0] pointer_select;
		logic [NUM_PTRS-1:0][PTR_WIDTH-1:0] dptr;
		csp_apb_rsp_type rsp;
		csp_map_type map;
		logic [7:0] status;
	} csp_state_type;

	csp_state_type state;
	csp_state_type next_state;

	function automatic logic odd_ones(input logic [7:0] v);
		return ^v;
	endfunction : odd_ones

	function automatic logic [7:0] pack_status(input csp_state_type s);
		return {s.carry_flag, s.nibble_carry_flag, s.user_flag_zero, s.bank_select_high,
			s.bank_select_low, s.signed_overflow_flag, s.user_flag_one, s.parity_flag};
	endfunction : pack_status

	function automatic logic wr_decoded(input logic [11:0] a);
		return a == CSP_OFS_STATUS || a == CSP_OFS_PSEL || a == CSP_OFS_ACC ||
			a == CSP_OFS_DPTR || a == CSP_OFS_CTRL;
	endfunction : wr_decoded

	logic wr_en;
	logic rd_en;
	logic [7:0] opb;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] res;
	logic [7:0] wbyte;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign wbyte = pwdata[7:0];
	assign opb = pwdata[CSP_CTRL_OPB_HI:CSP_CTRL_OPB_LO];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		sum9 = 9'h000;
		sum5 = 5'h00;
		res = 8'h00;
		next_state.rst_meta = core_reset;
		next_state.rst_sync = state.rst_meta;
		next_state.rsp.pready = 1'b0;
		next_state.rsp.pslverr = 1'b0;
		next_state.rsp.prdata = 32'h00000000;
		if (state.rst_sync)
		begin
			next_state.carry_flag = 1'b0;
			next_state.nibble_carry_flag = 1'b0;
			next_state.user_flag_zero = 1'b0;
			next_state.bank_select_high = 1'b0;
			next_state.bank_select_low = 1'b0;
			next_state.signed_overflow_flag = 1'b0;
			next_state.user_flag_one = 1'b0;
			next_state.acc = 8'h00;
			next_state.pointer_select = CSP_PSEL_RST;
			next_state.dptr = '0;
		end
		else if (wr_en && state.rsp.pready)
		begin
			// Writes land at the edge the master sees pready
			if (pstrb[0])
			begin
				unique case (paddr)
					CSP_OFS_STATUS:
					begin
						// Parity bit ignored, recomputed below
						next_state.carry_flag = wbyte[CSP_BIT_CARRY];
						next_state.nibble_carry_flag = wbyte[CSP_BIT_NIBBLE];
						next_state.user_flag_zero = wbyte[CSP_BIT_UF0];
						next_state.bank_select_high = wbyte[CSP_BIT_BANK_HI];
						next_state.bank_select_low = wbyte[CSP_BIT_BANK_LO];
						next_state.signed_overflow_flag = wbyte[CSP_BIT_OVF];
						next_state.user_flag_one = wbyte[CSP_BIT_UF1];
					end
					CSP_OFS_PSEL:
						next_state.pointer_select = wbyte[2:0];
					CSP_OFS_ACC:
						next_state.acc = wbyte;
					CSP_OFS_DPTR:
						if (pstrb[1])
							next_state.dptr[state.pointer_select] = pwdata[15:0];
					CSP_OFS_CTRL:
					begin
						if (pwdata[CSP_CTRL_INC])
							next_state.dptr[state.pointer_select] =
								state.dptr[state.pointer_select] + 16'h0001;
						if (pwdata[CSP_CTRL_ARITH])
						begin
							if (pwdata[CSP_CTRL_SUB])
							begin
								sum9 = {1'b0, state.acc} - {1'b0, opb}
									- {8'h00, pwdata[CSP_CTRL_CIN]};
								sum5 = {1'b0, state.acc[3:0]} - {1'b0, opb[3:0]}
									- {4'h0, pwdata[CSP_CTRL_CIN]};
							end
							else
							begin
								sum9 = {1'b0, state.acc} + {1'b0, opb}
									+ {8'h00, pwdata[CSP_CTRL_CIN]};
								sum5 = {1'b0, state.acc[3:0]} + {1'b0, opb[3:0]}
									+ {4'h0, pwdata[CSP_CTRL_CIN]};
							end
							res = sum9[7:0];
							next_state.acc = res;
							next_state.carry_flag = sum9[8];
							next_state.nibble_carry_flag = sum5[4];
							next_state.signed_overflow_flag = pwdata[CSP_CTRL_SUB] ?
								((state.acc[7] != opb[7]) && (res[7] != state.acc[7])) :
								((state.acc[7] == opb[7]) && (res[7] != state.acc[7]));
						end
					end
					default:
						next_state.rsp.pslverr = 1'b0;
				endcase
			end
		end
		else if (psel && !penable)
		begin
			next_state.rsp.pready = 1'b1;
			if (pwrite)
				next_state.rsp.pslverr = pstrb[0] && !wr_decoded(paddr);
			else
			begin
				unique case (paddr)
					CSP_OFS_STATUS:
						next_state.rsp.prdata = {24'h000000, state.status};
					CSP_OFS_PSEL:
						next_state.rsp.prdata = {29'h00000000, state.pointer_select};
					CSP_OFS_ACC:
						next_state.rsp.prdata = {24'h000000, state.acc};
					CSP_OFS_DPTR:
						next_state.rsp.prdata = {16'h0000, state.dptr[state.pointer_select]};
					CSP_OFS_CTRL:
						next_state.rsp.prdata = 32'h00000000;
					CSP_OFS_MAP:
						next_state.rsp.prdata = {8'h00, state.map.bank_base,
							state.map.ext_addr};
					default:
						next_state.rsp.pslverr = 1'b1;
				endcase
			end
		end
		next_state.parity_flag = odd_ones(next_state.acc);
		next_state.map.bank_base = 8'({next_state.bank_select_high,
			next_state.bank_select_low}) * 8'(CSP_BANK_BYTES);
		next_state.map.ext_addr = next_state.dptr[next_state.pointer_select];
		next_state.status = pack_status(next_state);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= '0;
		end
		else if (clk_en)
		begin
			state <= next_state;
		end
	end

	assign apb_rsp = state.rsp;
	assign map_out = state.map;
	assign status_out = state.status;
	assign core_in_reset = state.rst_sync;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [8:0] sfr_probe;
	assign sfr_probe = 9'(CSP_SFR_BASE) + 9'(CSP_SFR_BYTES - 1);
	logic wr_commit;
	logic arith_commit;
	assign wr_commit = clk_en && !state.rst_sync && wr_en && pstrb[0] && state.rsp.pready;
	assign arith_commit = wr_commit && paddr == CSP_OFS_CTRL && pwdata[CSP_CTRL_ARITH];

	chk_parity_tracks_acc: assert property (@(posedge pclk) disable iff (!presetn)
		state.parity_flag == ^state.acc) else $error("parity flag disagrees with acc");
	chk_bank_base_map: assert property (@(posedge pclk) disable iff (!presetn)
		state.map.bank_base == {3'h0, state.bank_select_high, state.bank_select_low, 3'h0})
		else $error("bank base wrong");
	chk_ptr_route: assert property (@(posedge pclk) disable iff (!presetn)
		state.map.ext_addr == state.dptr[state.pointer_select]) else $error("pointer route wrong");
	chk_reset_psel: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state.rst_sync |=> state.pointer_select == 3'h0)
		else $error("pointer select not cleared");
	chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en ##1 clk_en && $rose(state.rst_sync) |-> $past(core_reset, 2))
		else $error("reset not synchronised");
	chk_status_layout: assert property (@(posedge pclk) disable iff (!presetn)
		status_out[CSP_BIT_CARRY] == state.carry_flag &&
		status_out[CSP_BIT_OVF] == state.signed_overflow_flag)
		else $error("status layout wrong");
	chk_carry_add: assert property (@(posedge pclk) disable iff (!presetn)
		arith_commit && !pwdata[CSP_CTRL_SUB] |=>
		{state.carry_flag, state.acc} == $past({1'b0, state.acc}) + $past({1'b0, opb})
		+ $past({8'h00, pwdata[CSP_CTRL_CIN]})) else $error("carry wrong");
	chk_borrow_sub: assert property (@(posedge pclk) disable iff (!presetn)
		arith_commit && pwdata[CSP_CTRL_SUB] |=>
		{state.carry_flag, state.acc} == $past({1'b0, state.acc}) - $past({1'b0, opb})
		- $past({8'h00, pwdata[CSP_CTRL_CIN]})) else $error("borrow wrong");
	chk_nibble_add: assert property (@(posedge pclk) disable iff (!presetn)
		arith_commit && !pwdata[CSP_CTRL_SUB] |=>
		state.nibble_carry_flag == ($past(state.acc[3:0]) + $past(opb[3:0])
		+ $past(4'(pwdata[CSP_CTRL_CIN])) > 5'h0f)) else $error("nibble carry wrong");
	chk_ovf_add: assert property (@(posedge pclk) disable iff (!presetn)
		arith_commit && !pwdata[CSP_CTRL_SUB] |=>
		state.signed_overflow_flag == ($past(state.acc[7]) == $past(opb[7]) &&
		state.acc[7] != $past(state.acc[7]))) else $error("add overflow wrong");
	chk_ovf_sub: assert property (@(posedge pclk) disable iff (!presetn)
		arith_commit && pwdata[CSP_CTRL_SUB] |=>
		state.signed_overflow_flag == ($past(state.acc[7]) != $past(opb[7]) &&
		state.acc[7] != $past(state.acc[7]))) else $error("sub overflow wrong");
	chk_status_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_commit && paddr == CSP_OFS_STATUS |=> status_out[CSP_BIT_CARRY:CSP_BIT_UF1] ==
		$past(pwdata[CSP_BIT_CARRY:CSP_BIT_UF1])) else $error("status write wrong");
	chk_parity_owned: assert property (@(posedge pclk) disable iff (!presetn)
		wr_commit && paddr == CSP_OFS_STATUS |=> status_out[CSP_BIT_PARITY] == ^state.acc)
		else $error("parity bit took a write");
	chk_bank_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_commit && paddr == CSP_OFS_STATUS |=> map_out.bank_base ==
		{3'h0, $past(pwdata[CSP_BIT_BANK_HI:CSP_BIT_BANK_LO]), 3'h0})
		else $error("bank write wrong");
	chk_psel_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_commit && paddr == CSP_OFS_PSEL |=> state.pointer_select == $past(pwdata[2:0]))
		else $error("pointer select write wrong");
	chk_dptr_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_commit && pstrb[1] && paddr == CSP_OFS_DPTR |=>
		map_out.ext_addr == $past(pwdata[15:0])) else $error("pointer write wrong");
	chk_dptr_inc: assert property (@(posedge pclk) disable iff (!presetn)
		wr_commit && paddr == CSP_OFS_CTRL && pwdata[CSP_CTRL_INC] |=>
		map_out.ext_addr == $past(map_out.ext_addr) + 16'h0001) else $error("increment wrong");
	chk_sync_release: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en ##1 clk_en && $fell(state.rst_sync) |-> !$past(core_reset, 2))
		else $error("reset release not synchronised");
	chk_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && state.rst_sync |=>
		status_out == CSP_STATUS_RST && map_out.ext_addr == 16'h0000)
		else $error("reset did not clear state");
	chk_read_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !state.rst_sync && rd_en |=> $stable(status_out))
		else $error("read changed the status word");
	chk_sfr_span: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !state.rst_sync && psel && !penable && (!pwrite || pstrb[0]) &&
		paddr >= {4'h0, CSP_SFR_BASE} && paddr <= {3'h0, sfr_probe} &&
		paddr != CSP_OFS_STATUS && paddr != CSP_OFS_PSEL |=> state.rsp.pslverr)
		else $error("sfr decode wrong");
	chk_idata_size: assert property (@(posedge pclk) disable iff (!presetn)
		{1'b0, state.map.bank_base} + 9'(CSP_BANK_BYTES) <= 9'(CSP_IDATA_BYTES))
		else $error("bank outside data memory");
endmodule : csp_core

// ==== bench/cpu_status_and_pointer_select_tb.sv ====
// Self-checking bench for the status word and pointer-select block
`timescale 1ns/1ps
module cpu_status_and_pointer_select_tb;
	import csp_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic core_reset = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hf;
	csp_apb_rsp_type apb_rsp;
	csp_map_type map_out;
	logic [7:0] status_out;
	logic core_in_reset;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic err;

	csp_core dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .core_reset(core_reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .apb_rsp(apb_rsp), .map_out(map_out), .status_out(status_out),
		.core_in_reset(core_in_reset));

	// ----------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------
	initial
	begin
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, CSP_OFS_STATUS, 32'h0);
		check(rd, {24'h0, CSP_STATUS_RST});
		xfer(1'b0, CSP_OFS_PSEL, 32'h0);
		check(rd, {29'h0, CSP_PSEL_RST});
		for (int i = 0; i < 8; i++)
		begin
			xfer(1'b1, CSP_OFS_PSEL, 32'(i));
			xfer(1'b1, CSP_OFS_DPTR, 32'h1000 + 32'(i) * 32'h0111);
		end
		for (int i = 7; i >= 0; i--)
		begin
			xfer(1'b1, CSP_OFS_PSEL, 32'(i) | 32'hf8);
			xfer(1'b0, CSP_OFS_PSEL, 32'h0);
			check(rd, 32'(i));
			xfer(1'b0, CSP_OFS_DPTR, 32'h0);
			check(rd, 32'h1000 + 32'(i) * 32'h0111);
			check({16'h0, map_out.ext_addr}, 32'h1000 + 32'(i) * 32'h0111);
		end
		xfer(1'b1, CSP_OFS_CTRL, 32'h10);
		xfer(1'b0, CSP_OFS_DPTR, 32'h0);
		check(rd, 32'h1001);
		for (int b = 0; b < 4; b++)
		begin
			xfer(1'b1, CSP_OFS_STATUS, 32'(b) << CSP_BIT_BANK_LO);
			@(posedge pclk);
			check({24'h0, map_out.bank_base}, 32'(b) * 32'h8);
			check({24'h0, status_out}, 32'(b) << CSP_BIT_BANK_LO);
		end
		xfer(1'b0, CSP_OFS_MAP, 32'h0);
		check(rd, 32'h00181001);
		xfer(1'b1, CSP_OFS_ACC, 32'h07);
		xfer(1'b1, CSP_OFS_STATUS, 32'h22);
		xfer(1'b0, CSP_OFS_STATUS, 32'h0);
		check(rd, 32'h23);
		xfer(1'b1, CSP_OFS_ACC, 32'h06);
		xfer(1'b0, CSP_OFS_STATUS, 32'h0);
		check(rd, 32'h22);
		xfer(1'b1, CSP_OFS_STATUS, 32'h0);
		xfer(1'b1, CSP_OFS_ACC, 32'h7f);
		xfer(1'b1, CSP_OFS_CTRL, 32'h0102);
		xfer(1'b0, CSP_OFS_STATUS, 32'h0);
		check(rd, 32'h45);
		xfer(1'b1, CSP_OFS_ACC, 32'h00);
		xfer(1'b1, CSP_OFS_CTRL, 32'h0106);
		xfer(1'b0, CSP_OFS_ACC, 32'h0);
		check(rd, 32'hff);
		xfer(1'b0, CSP_OFS_STATUS, 32'h0);
		check(rd, 32'hc0);
		xfer(1'b0, 12'h0f0, 32'h0);
		check({31'h0, err}, 32'h1);
		@(posedge pclk);
		clk_en <= 1'b0;
		core_reset <= 1'b1;
		repeat (4) @(posedge pclk);
		check({31'h0, core_in_reset}, 32'h0);
		clk_en <= 1'b1;
		repeat (CSP_RESET_OSC_PERIODS + 2) @(posedge pclk);
		check({31'h0, core_in_reset}, 32'h1);
		check({24'h0, status_out}, {24'h0, CSP_STATUS_RST});
		core_reset <= 1'b0;
		repeat (4) @(posedge pclk);
		check({31'h0, core_in_reset}, 32'h0);
		give_verdict();
	end
endmodule : cpu_status_and_pointer_select_tb
